// ===== sgmx_step_config.v
// Step 3 gain, step 0/1 diode routing and saturation enable register bank
`timescale 1ns/1ps
`include "sgmx_consts.vh"
module sgmx_step_config
(
  clk_sys,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  agc_gain_we,
  agc_gain_mod0,
  agc_gain_mod1,
  step3_gain_mod0,
  step3_gain_mod1,
  step3_gain_valid,
  step0_to_mod0,
  step0_to_mod1,
  step1_to_mod0,
  step1_to_mod1,
  seq_step,
  sat_enable,
  sat_enable_now
);
  input  wire       clk_sys;
  input  wire       rst;
  input  wire [7:0] reg_addr;
  input  wire [7:0] reg_wdata;
  input  wire       reg_wr;
  input  wire       reg_rd;
  output reg  [7:0] reg_rdata;
  input  wire       agc_gain_we;
  input  wire [3:0] agc_gain_mod0;
  input  wire [3:0] agc_gain_mod1;
  output wire [3:0] step3_gain_mod0;
  output wire [3:0] step3_gain_mod1;
  output wire       step3_gain_valid;
  output wire [5:0] step0_to_mod0;
  output wire [5:0] step0_to_mod1;
  output wire [5:0] step1_to_mod0;
  output wire [5:0] step1_to_mod1;
  input  wire [1:0] seq_step;
  output wire [3:0] sat_enable;
  output wire       sat_enable_now;

  // Software-visible routing and pattern storage
  reg  [7:0]  s0_low_r;
  reg  [3:0]  s0_high_r;
  reg  [7:0]  s1_low_r;
  reg  [3:0]  s1_high_r;
  reg  [3:0]  sat_r;
  reg  [7:0]  rdata_nxt;
  // Registered connect masks towards the diode switches
  reg  [5:0]  s0_mod0_r;
  reg  [5:0]  s0_mod1_r;
  reg  [5:0]  s1_mod0_r;
  reg  [5:0]  s1_mod1_r;
  // Gain path and write strobes
  wire [3:0]  gain0;
  wire [3:0]  gain1;
  wire [3:0]  agc_code0;
  wire [3:0]  agc_code1;
  wire        sw_gain_we;
  wire        agc_sat_on;
  wire        wr_s0_low;
  wire        wr_s0_high;
  wire        wr_s1_low;
  wire        wr_s1_high;
  // Read-back words and routing decode
  wire [7:0]  rb_gain3;
  wire [7:0]  rb_s0_high;
  wire [7:0]  rb_s1_high;
  wire [11:0] s0_fields;
  wire [11:0] s1_fields;
  wire [5:0]  s0_mod0_nxt;
  wire [5:0]  s0_mod1_nxt;
  wire [5:0]  s1_mod0_nxt;
  wire [5:0]  s1_mod1_nxt;

  // Limit a gain code to the defined range 1/2x .. 4096x
  function [3:0] sgmx_clip_gain;
    input [3:0] code;
    begin
      if (code > `SGMX_GAIN_MAX)
      begin
        sgmx_clip_gain = `SGMX_GAIN_MAX;
      end
      else
      begin
        sgmx_clip_gain = code;
      end
    end
  endfunction

  // Address match helper for writes
  function wr_hit;
    input       wr;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = wr && (addr == ofs);
    end
  endfunction

  // Join a high nibble and a low byte into six two-bit diode fields
  function [11:0] sgmx_route_word;
    input [3:0] high;
    input [7:0] low;
    begin
      sgmx_route_word = {high, low};
    end
  endfunction

  // One write strobe per register, decoded from the byte address
  assign sw_gain_we = wr_hit(reg_wr, reg_addr, `SGMX_OFS_GAIN3);
  assign wr_s0_low  = wr_hit(reg_wr, reg_addr, `SGMX_OFS_S0_LOW);
  assign wr_s0_high = wr_hit(reg_wr, reg_addr, `SGMX_OFS_S0_HIGH);
  assign wr_s1_low  = wr_hit(reg_wr, reg_addr, `SGMX_OFS_S1_LOW);
  assign wr_s1_high = wr_hit(reg_wr, reg_addr, `SGMX_OFS_S1_HIGH);

  // Gain control only writes step 3 gains while saturation AGC is on
  assign agc_sat_on = agc_gain_we & sat_r[`SGMX_STEP3_BIT];
  // Codes beyond the top step are held at 4096x, not wrapped
  assign agc_code0  = sgmx_clip_gain(agc_gain_mod0);
  assign agc_code1  = sgmx_clip_gain(agc_gain_mod1);

  // Modulator 0 gain in the low nibble
  sgmx_gain_reg u_gain0
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .sw_we    (sw_gain_we),
    .sw_data  (reg_wdata[`SGMX_LO_NIB]),
    .agc_we   (agc_sat_on),
    .agc_data (agc_code0),
    .gain     (gain0)
  );

  // Modulator 1 gain in the high nibble
  sgmx_gain_reg u_gain1
  (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .sw_we    (sw_gain_we),
    .sw_data  (reg_wdata[`SGMX_HI_NIB]),
    .agc_we   (agc_sat_on),
    .agc_data (agc_code1),
    .gain     (gain1)
  );

  // Gains leave straight from their flip-flops
  assign step3_gain_mod0  = gain0;
  assign step3_gain_mod1  = gain1;
  // Stored code is inside the defined gain range
  assign step3_gain_valid = (gain0 <= `SGMX_GAIN_MAX) &&
                            (gain1 <= `SGMX_GAIN_MAX);

  // Step 0 low routing byte, diodes 3..0
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s0_low_r <= `SGMX_RST_S0_LOW;
    end
    else if (wr_s0_low)
    begin
      s0_low_r <= reg_wdata;
    end
  end

  // Step 0 high routing nibble, diodes 5 and 4; bits 7:4 reserved
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s0_high_r <= `SGMX_RST_S0_HIGH;
    end
    else if (wr_s0_high)
    begin
      s0_high_r <= reg_wdata[`SGMX_LO_NIB];
    end
  end

  // Step 1 low routing byte, diodes 3..0
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_low_r <= `SGMX_RST_S1_LOW;
    end
    else if (wr_s1_low)
    begin
      s1_low_r <= reg_wdata;
    end
  end

  // Step 1 high routing nibble, diodes 5 and 4
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_high_r <= `SGMX_RST_S1_HIGH;
    end
    else if (wr_s1_high)
    begin
      s1_high_r <= reg_wdata[`SGMX_LO_NIB];
    end
  end

  // Saturation AGC step pattern shares the step 1 high byte
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sat_r <= `SGMX_RST_SAT;
    end
    else if (wr_s1_high)
    begin
      sat_r <= reg_wdata[`SGMX_HI_NIB];
    end
  end

  // Read-back words; reserved and unmapped bits read zero
  assign rb_gain3   = {gain1, gain0};
  assign rb_s0_high = {`SGMX_ZERO4, s0_high_r};
  assign rb_s1_high = {sat_r, s1_high_r};

  // Read multiplexer
  always @*
  begin
    rdata_nxt = `SGMX_ZERO8;
    case (reg_addr)
      `SGMX_OFS_GAIN3:   rdata_nxt = rb_gain3;
      `SGMX_OFS_S0_LOW:  rdata_nxt = s0_low_r;
      `SGMX_OFS_S0_HIGH: rdata_nxt = rb_s0_high;
      `SGMX_OFS_S1_LOW:  rdata_nxt = s1_low_r;
      `SGMX_OFS_S1_HIGH: rdata_nxt = rb_s1_high;
      default:           rdata_nxt = `SGMX_ZERO8;
    endcase
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata <= `SGMX_ZERO8;
    end
    else if (reg_rd)
    begin
      reg_rdata <= rdata_nxt;
    end
    else
    begin
      reg_rdata <= `SGMX_ZERO8;
    end
  end

  // Both routing words as six two-bit diode fields
  assign s0_fields = sgmx_route_word(s0_high_r, s0_low_r);
  assign s1_fields = sgmx_route_word(s1_high_r, s1_low_r);

  // Diode 5..0 routing of step 0
  sgmx_route_decode u_dec0
  (
    .routing (s0_fields),
    .to_mod0 (s0_mod0_nxt),
    .to_mod1 (s0_mod1_nxt)
  );

  // Diode 5..0 routing of step 1
  sgmx_route_decode u_dec1
  (
    .routing (s1_fields),
    .to_mod0 (s1_mod0_nxt),
    .to_mod1 (s1_mod1_nxt)
  );

  // Step 0 modulator 0 mask; registered so switches never see glitches
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s0_mod0_r <= `SGMX_RST_S0_M0;
    end
    else
    begin
      s0_mod0_r <= s0_mod0_nxt;
    end
  end

  // Step 0 modulator 1 mask, one cycle behind a routing write
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s0_mod1_r <= `SGMX_RST_S0_M1;
    end
    else
    begin
      s0_mod1_r <= s0_mod1_nxt;
    end
  end

  // Step 1 modulator 0 mask, one cycle behind a routing write
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_mod0_r <= `SGMX_RST_S1_M0;
    end
    else
    begin
      s1_mod0_r <= s1_mod0_nxt;
    end
  end

  // Step 1 modulator 1 mask; code 11 connects to neither modulator
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s1_mod1_r <= `SGMX_RST_S1_M1;
    end
    else
    begin
      s1_mod1_r <= s1_mod1_nxt;
    end
  end

  // Connect masks leave from their flip-flops
  assign step0_to_mod0 = s0_mod0_r;
  assign step0_to_mod1 = s0_mod1_r;
  assign step1_to_mod0 = s1_mod0_r;
  assign step1_to_mod1 = s1_mod1_r;

  // Bitwise enable per step; bit 3 is step 3, bit 0 step 0
  assign sat_enable     = sat_r;
  assign sat_enable_now = sat_r[seq_step];
endmodule

// ===== sgmx_consts.vh
// Constants for the sequencer step gain and diode routing register bank
`ifndef SGMX_CONSTS_VH
`define SGMX_CONSTS_VH
`define SGMX_ADDR_W          8
`define SGMX_DATA_W          8
`define SGMX_OFS_GAIN3       8'hda
`define SGMX_OFS_S0_LOW      8'hdc
`define SGMX_OFS_S0_HIGH     8'hdd
`define SGMX_OFS_S1_LOW      8'hde
`define SGMX_OFS_S1_HIGH     8'hdf
`define SGMX_RST_GAIN        4'h8
`define SGMX_RST_S0_LOW      8'h66
`define SGMX_RST_S0_HIGH     4'h6
`define SGMX_RST_S1_LOW      8'h84
`define SGMX_RST_S1_HIGH     4'h3
`define SGMX_RST_SAT         4'hf
`define SGMX_GAIN_MAX        4'hd
`define SGMX_SEL_NONE        2'h0
`define SGMX_SEL_MOD0        2'h1
`define SGMX_SEL_MOD1        2'h2
`define SGMX_NUM_DIODES      6
`define SGMX_ZERO4           4'h0
`define SGMX_ZERO8           8'h00
`define SGMX_RST_S0_M0       6'h2a
`define SGMX_RST_S0_M1       6'h15
`define SGMX_RST_S1_M0       6'h02
`define SGMX_RST_S1_M1       6'h08
`define SGMX_STEP3_BIT       3
`define SGMX_LO_NIB          3:0
`define SGMX_HI_NIB          7:4
`endif

// ===== sgmx_route_decode.v
// Decoder turning six two-bit routing fields into modulator connect masks
`timescale 1ns/1ps
`include "sgmx_consts.vh"
module sgmx_route_decode
(
  routing,
  to_mod0,
  to_mod1
);
  input  wire [11:0] routing;
  output reg  [5:0]  to_mod0;
  output reg  [5:0]  to_mod1;

  integer i;

  // Code 01 joins modulator 0, 10 joins modulator 1, others leave it open
  always @*
  begin
    to_mod0 = 6'h00;
    to_mod1 = 6'h00;
    for (i = 0; i < `SGMX_NUM_DIODES; i = i + 1)
    begin
      to_mod0[i] = (routing[2*i +: 2] == `SGMX_SEL_MOD0);
      to_mod1[i] = (routing[2*i +: 2] == `SGMX_SEL_MOD1);
    end
  end
endmodule

// ===== sgmx_gain_reg.v
// One four-bit gain code, written by software or by gain control
`timescale 1ns/1ps
`include "sgmx_consts.vh"
module sgmx_gain_reg
(
  clk_sys,
  rst,
  sw_we,
  sw_data,
  agc_we,
  agc_data,
  gain
);
  input  wire       clk_sys;
  input  wire       rst;
  input  wire       sw_we;
  input  wire [3:0] sw_data;
  input  wire       agc_we;
  input  wire [3:0] agc_data;
  output wire [3:0] gain;

  reg [3:0] gain_r;

  assign gain = gain_r;

  // Gain control update wins over a software write in the same cycle
  always @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      gain_r <= `SGMX_RST_GAIN;
    else if (agc_we)
      gain_r <= agc_data;
    else if (sw_we)
      gain_r <= sw_data;
  end
endmodule

// ===== sgmx_step_config_sva.sv
// Checker for the step gain and routing register bank
`timescale 1ns/1ps
module sgmx_step_config_sva
(
  input wire       clk_sys,
  input wire       rst,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       agc_gain_we,
  input wire [3:0] agc_gain_mod0,
  input wire [3:0] agc_gain_mod1,
  input wire [5:0] step1_to_mod0,
  input wire [5:0] step1_to_mod1,
  input wire [3:0] step3_gain_mod0,
  input wire [3:0] step3_gain_mod1,
  input wire       step3_gain_valid,
  input wire [5:0] step0_to_mod0,
  input wire [5:0] step0_to_mod1,
  input wire [3:0] sat_enable,
  input wire [1:0] seq_step,
  input wire       sat_enable_now
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Register, decode and gain control relations
  chk_rsv_zero: assert property (reg_rd && reg_addr == 8'hdd |=>
    reg_rdata[7:4] == 4'h0) else $error("reserved bits set");
  chk_gain_wr: assert property (reg_wr && reg_addr == 8'hda
    && !agc_gain_we |=> {step3_gain_mod1, step3_gain_mod0}
    == $past(reg_wdata)) else $error("gain write lost");
  chk_sat_rd: assert property (reg_rd && reg_addr == 8'hdf |=>
    reg_rdata[7:4] == $past(sat_enable)) else $error("pattern read");
  chk_sat_now: assert property (sat_enable_now ==
    sat_enable[seq_step]) else $error("step enable wrong");
  chk_route_excl: assert property (!(step0_to_mod0 &
    step0_to_mod1)) else $error("diode on both");
  chk_agc_wr: assert property (agc_gain_we && sat_enable[3] |=>
    step3_gain_mod0 == ($past(agc_gain_mod0) > 4'hd ? 4'hd
    : $past(agc_gain_mod0))) else $error("agc write lost");
  chk_agc_wr1: assert property (agc_gain_we && sat_enable[3] |=>
    step3_gain_mod1 == ($past(agc_gain_mod1) > 4'hd ? 4'hd
    : $past(agc_gain_mod1))) else $error("agc high write lost");
  chk_route_ex1: assert property (!(step1_to_mod0 &
    step1_to_mod1)) else $error("step 1 diode on both");
  chk_agc_off: assert property (agc_gain_we && !sat_enable[3]
    && !reg_wr |=> $stable(step3_gain_mod0)) else $error("agc leak");
  chk_gain_ok: assert property (step3_gain_valid ==
    (step3_gain_mod0 <= 4'hd && step3_gain_mod1 <= 4'hd))
    else $error("valid flag wrong");
  // Main scenarios reached
  cover property (agc_gain_we && sat_enable[3]);
  cover property (reg_rd && reg_addr == 8'hdd);
  cover property (!step3_gain_valid);
  cover property (agc_gain_we && sat_enable[3] && reg_wr
    && reg_addr == 8'hda);
endmodule
bind sgmx_step_config sgmx_step_config_sva u_sva (.*);

// ===== testbench.sv
// Self-checking bench for the step gain and routing register bank
`timescale 1ns/1ps
`define CHK(a,b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("BAD %0t %h %h", $time, a, b); end end
module testbench;
  logic       clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic       agc_gain_we = 0, step3_gain_valid, sat_enable_now;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, lf = 8'h59;
  logic [3:0] agc_gain_mod0 = 0, agc_gain_mod1 = 0;
  logic [3:0] step3_gain_mod0, step3_gain_mod1, sat_enable;
  logic [5:0] step0_to_mod0, step0_to_mod1, step1_to_mod0, step1_to_mod1;
  logic [1:0] seq_step = 0;
  logic [7:0] sh[5], ad[5], mk[5];
  int         fail_count = 0, tests_run = 0, cyc = 0, k;
  sgmx_step_config i_dut (.*);
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [5:0] dec(input logic [11:0] f, logic [1:0] c);
    for (int i = 0; i < 6; i++)
      dec[i] = f[2*i+:2] == c;
  endfunction
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge clk_sys);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 `CHK(reg_rdata, e)
  endtask
  // Compare every output except reg_rdata with the shadow copy
  task automatic outs;
    `CHK({step3_gain_mod1, step3_gain_mod0}, sh[0])
    `CHK(step0_to_mod0, dec({sh[2][3:0], sh[1]}, 1))
    `CHK(step0_to_mod1, dec({sh[2][3:0], sh[1]}, 2))
    `CHK(step1_to_mod0, dec({sh[4][3:0], sh[3]}, 1))
    `CHK(step1_to_mod1, dec({sh[4][3:0], sh[3]}, 2))
    `CHK(sat_enable, sh[4][7:4])
    `CHK(sat_enable_now, sh[4][4 + seq_step])
    `CHK(step3_gain_valid, sh[0][7:4] < 14 && sh[0][3:0] < 14)
  endtask
  task wrap_up;
    $display("run %0d bad %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      fail_count++;
      wrap_up;
    end
  end
  // Reset values, random traffic, unmapped place, gain control
  initial
  begin
    ad = '{8'hda, 8'hdc, 8'hdd, 8'hde, 8'hdf};
    mk = '{8'hff, 8'hff, 8'h0f, 8'hff, 8'hff};
    sh = '{8'h88, 8'h66, 8'h06, 8'h84, 8'hf3};
    repeat (6) @(posedge clk_sys);
    rst <= 0;
    rd(8'hda, 8'h88);
    rd(8'hdc, 8'h66);
    rd(8'hdd, 8'h06);
    rd(8'hde, 8'h84);
    rd(8'hdf, 8'hf3);
    outs;
    $display("reset test done");
    for (int n = 0; n < 40; n++)
    begin
      lf = nx(lf);
      k = lf % 5;
      wr(ad[k], nx(lf));
      sh[k] = nx(lf) & mk[k];
      seq_step <= lf[1:0];
      rd(ad[k], sh[k]);
      outs;
    end
    wr(8'hdb, 8'hff);
    rd(8'hdb, 8'h00);
    outs;
    $display("random test done");
    for (int s = 0; s < 2; s++)
    begin
      wr(8'hdf, {s[0], 7'h00});
      sh[4] = {s[0], 7'h00};
      @(posedge clk_sys);
      agc_gain_we <= 1;
      agc_gain_mod0 <= 4'he;
      agc_gain_mod1 <= 4'h3;
      @(posedge clk_sys);
      agc_gain_we <= 0;
      if (s)
        sh[0] = 8'h3d;
      #1 outs;
    end
    // Gain control and software hit the gain register together
    @(posedge clk_sys);
    reg_wr <= 1;
    reg_addr <= 8'hda;
    reg_wdata <= 8'h55;
    agc_gain_we <= 1;
    agc_gain_mod0 <= 4'h2;
    agc_gain_mod1 <= 4'hf;
    @(posedge clk_sys);
    reg_wr <= 0;
    agc_gain_we <= 0;
    sh[0] = 8'hd2;
    #1 outs;
    $display("gain control test done");
    // Reset again in mid-run
    @(posedge clk_sys);
    rst <= 1;
    @(posedge clk_sys);
    rst <= 0;
    sh = '{8'h88, 8'h66, 8'h06, 8'h84, 8'hf3};
    #1 outs;
    rd(8'hdf, 8'hf3);
    $display("mid-run reset test done");
    wrap_up;
  end
endmodule
